// ---- hw/bus_glue_pkg.sv ----
// Shared constants for the CPU to system bus glue and its failsafe timer.
package bus_glue_pkg;
    // Number of pins that pass the two-stage synchroniser.
    localparam int unsigned PIN_COUNT = 23;
    // Idle levels of the synchronised pins, in the glue's pin order.
    localparam logic [22:0] PIN_IDLE = 23'h7C_BBBE;
    // Core clock rate in hertz.
    localparam longint unsigned CLOCK_HZ = 100_000_000;
    // Failsafe window as a time in milliseconds.
    localparam longint unsigned FAILSAFE_TIME_MS = 9;
    // Failsafe window in core clock cycles, rounded down.
    localparam int unsigned FAILSAFE_CYCLES =
        int'((FAILSAFE_TIME_MS * CLOCK_HZ) / 1000);
    // Width of the failsafe cycle counter.
    localparam int unsigned FAILSAFE_WIDTH = 20;
    // Reset value of the failsafe counter.
    localparam logic [19:0] FAILSAFE_COUNT_RESET = 20'h0_0000;
    // Reset levels of active-high and active-low outputs.
    localparam logic RESET_HIGH_OFF = 1'b0;
    localparam logic RESET_LOW_OFF = 1'b1;
    // Reset level of the processor reset output (held in reset).
    localparam logic RESET_CPU_HELD = 1'b1;
    // Failsafe timer state.
    typedef enum logic [1:0] {
        FS_COUNTING,
        FS_INT_ACK,
        FS_TIMED_OUT
    } failsafe_state_t;
endpackage

// ---- hw/cpu_bus_glue.sv ----
// Glue between the CPU group and the shared multi-master system bus.
// Summary of operation
// - OR four interrupt requests into the processor interrupt input.
// - Invert the active-low bus hold request onto the CPU hold input.
// - Latch hold acknowledge; float the four command drivers while set.
// - Latched acknowledge drives address and external data chip selects high.
// - Bus-in-use output is the inverted latched hold acknowledge.
// - With reset-out selected, drive power-up reset onto bus reset.
// - Bus reset from others resets the processor and board logic.
// - I/O ready when any peripheral select meets I/O read or early write.
// - I/O write command is the early write qualified by write strobe.
// - Processor must see ready before entering T3 of each cycle.
// - Without ready after T2 the processor waits with data stable.
// - OR failsafe, I/O, ROM and RAM ready; this disables external data.
// - OR local ready with both external acknowledges into CPU ready.
// - Divide the clock by two onto common and bus clock lines.
// - Local memory transceivers selected by RAM or ROM ready, memory read.
// - External data points inward on any read, disabled during hold.
// - Address bus is driven outbound only, never received.
// - Supply ready so the forced restart instruction can be read.
// - Status bit 0 at status strobe forces interrupt acknowledge ready.
// - Failsafe retriggers per strobe, times out after 9 ms.
module cpu_bus_glue
#(
    parameter int unsigned FAILSAFE_CYCLES = bus_glue_pkg::FAILSAFE_CYCLES
)
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic external_irq_one_n,
    input  wire logic external_irq_two_n,
    input  wire logic parallel_irq_n,
    input  wire logic serial_irq_n,
    input  wire logic bus_hold_request_n,
    input  wire logic cpu_bus_release_ack,
    input  wire logic power_up_reset,
    input  wire logic reset_out_enable,
    input  wire logic bus_reset_n_i,
    output logic      bus_reset_n_o,
    output logic      bus_reset_n_oe,
    input  wire logic serial_select_n,
    input  wire logic parallel_a_select_n,
    input  wire logic parallel_b_select_n,
    input  wire logic io_read_level,
    input  wire logic early_io_write_n,
    input  wire logic early_mem_write_n,
    input  wire logic cpu_write_strobe_n,
    input  wire logic memory_read_level,
    input  wire logic rom_ready_n,
    input  wire logic rw_memory_ready_n,
    input  wire logic advanced_transfer_ack_n,
    input  wire logic transfer_ack_n,
    input  wire logic status_strobe_n,
    input  wire logic status_bit0,
    output logic      cpu_irq,
    output logic      cpu_hold,
    output logic      latched_release_ack,
    output logic      bus_in_use_n,
    output logic      mem_read_command_n,
    output logic      mem_write_command_n,
    output logic      io_read_command_n,
    output logic      io_write_command_n,
    output logic      command_oe,
    output logic      address_cs_n,
    output logic      address_outbound,
    output logic      ext_data_cs_n,
    output logic      ext_data_inward,
    output logic      local_mem_cs_n,
    output logic      transceiver_direction,
    output logic      local_io_ready_n,
    output logic      cpu_ready_input,
    output logic      cpu_reset,
    output logic      board_reset,
    output logic      common_clock_n,
    output logic      bus_clock_n
);
    // Two-stage synchroniser for every pin input.
    logic [22:0] pin_meta;
    logic [22:0] pin_sync;
    wire  [22:0] pin_raw;

    // Synchronised copies of the pins.
    wire irq_one_s;
    wire irq_two_s;
    wire par_irq_s;
    wire ser_irq_s;
    wire hold_req_s;
    wire cpu_bus_release_ack_s;
    wire pwr_reset_s;
    wire bus_reset_s;
    wire reset_out_s;
    wire ser_sel_s;
    wire par_a_sel_s;
    wire par_b_sel_s;
    wire io_read_s;
    wire early_iow_s;
    wire early_memw_s;
    wire wr_strobe_s;
    wire mem_read_s;
    wire rom_rdy_s;
    wire ram_rdy_s;
    wire advanced_transfer_ack_n_s;
    wire transfer_ack_n_s;
    wire sts_strobe_s;
    wire sts_bit0_s;

    // Decoded terms.
    wire any_irq;
    wire any_select;
    wire io_ready;
    wire local_access;
    wire ready_any;
    wire reset_seen;
    wire drive_reset_out;
    wire any_read;
    wire mem_select;

    failsafe_if fs ();

    // The pin order here must match the idle pattern in the package.
    assign pin_raw =
    {
        external_irq_one_n,
        external_irq_two_n,
        parallel_irq_n,
        serial_irq_n,
        bus_hold_request_n,
        cpu_bus_release_ack,
        power_up_reset,
        bus_reset_n_i,
        reset_out_enable,
        serial_select_n,
        parallel_a_select_n,
        parallel_b_select_n,
        io_read_level,
        early_io_write_n,
        early_mem_write_n,
        cpu_write_strobe_n,
        memory_read_level,
        rom_ready_n,
        rw_memory_ready_n,
        advanced_transfer_ack_n,
        transfer_ack_n,
        status_strobe_n,
        status_bit0
    };

    // Every pin is asynchronous to core_clk, so it passes two flops.
    // Resetting to the idle levels avoids false events after release.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_meta <= bus_glue_pkg::PIN_IDLE;
            pin_sync <= bus_glue_pkg::PIN_IDLE;
        end
        else
        begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // Unpack the synchronised pins in the same order.
    assign
    {
        irq_one_s,
        irq_two_s,
        par_irq_s,
        ser_irq_s,
        hold_req_s,
        cpu_bus_release_ack_s,
        pwr_reset_s,
        bus_reset_s,
        reset_out_s,
        ser_sel_s,
        par_a_sel_s,
        par_b_sel_s,
        io_read_s,
        early_iow_s,
        early_memw_s,
        wr_strobe_s,
        mem_read_s,
        rom_rdy_s,
        ram_rdy_s,
        advanced_transfer_ack_n_s,
        transfer_ack_n_s,
        sts_strobe_s,
        sts_bit0_s
    } = pin_sync;

    assign any_irq = ~irq_one_s | ~irq_two_s | ~par_irq_s | ~ser_irq_s;

    assign any_select = ~ser_sel_s | ~par_a_sel_s | ~par_b_sel_s;
    // early write used for ready
    // The early write lets ready return in time to avoid a wait state.
    assign io_ready = any_select & (io_read_s | ~early_iow_s);

    // The failsafe sees the strobe as an active-high level.
    assign fs.strobe = ~sts_strobe_s;
    assign fs.status_bit0 = sts_bit0_s;

    assign local_access = fs.int_ack | fs.timeout | io_ready
                        | ~rom_rdy_s | ~ram_rdy_s;

    assign ready_any = local_access | ~advanced_transfer_ack_n_s | ~transfer_ack_n_s;

    assign drive_reset_out = reset_out_s & pwr_reset_s;
    // bus reset accepted
    // Our own driven reset is also seen here, so the board follows it.
    assign reset_seen = pwr_reset_s | ~bus_reset_s;

    assign any_read = mem_read_s | io_read_s;
    assign mem_select = ~rom_rdy_s | ~ram_rdy_s;

    failsafe_timer
    #(
        .TIMEOUT_CYCLES (FAILSAFE_CYCLES)
    )
    u_failsafe
    (
        .core_clk (core_clk),
        .rst      (rst),
        .fs       (fs.timer)
    );

    // Interrupt and hold path: requests to processor and latched acknowledge.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_irq <= bus_glue_pkg::RESET_HIGH_OFF;
            cpu_hold <= bus_glue_pkg::RESET_HIGH_OFF;
            latched_release_ack <= bus_glue_pkg::RESET_HIGH_OFF;
            bus_in_use_n <= bus_glue_pkg::RESET_LOW_OFF;
        end
        else
        begin
            cpu_irq <= any_irq;
            cpu_hold <= ~hold_req_s;
            latched_release_ack <= cpu_bus_release_ack_s;
            bus_in_use_n <= ~cpu_bus_release_ack_s;
        end
    end

    // Command drivers; the enable falls with the latched acknowledge.
    // Same delay as the latch, so both move together.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mem_read_command_n <= bus_glue_pkg::RESET_LOW_OFF;
            mem_write_command_n <= bus_glue_pkg::RESET_LOW_OFF;
            io_read_command_n <= bus_glue_pkg::RESET_LOW_OFF;
            io_write_command_n <= bus_glue_pkg::RESET_LOW_OFF;
            command_oe <= bus_glue_pkg::RESET_HIGH_OFF;
        end
        else
        begin
            mem_read_command_n <= ~mem_read_s;
            mem_write_command_n <= early_memw_s | wr_strobe_s;
            io_read_command_n <= ~io_read_s;
            io_write_command_n <= early_iow_s | wr_strobe_s;
            command_oe <= ~cpu_bus_release_ack_s;
        end
    end

    // Transceiver selects and directions.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            address_cs_n <= bus_glue_pkg::RESET_LOW_OFF;
            address_outbound <= 1'b1;
            ext_data_cs_n <= bus_glue_pkg::RESET_LOW_OFF;
            ext_data_inward <= bus_glue_pkg::RESET_HIGH_OFF;
            local_mem_cs_n <= bus_glue_pkg::RESET_LOW_OFF;
            transceiver_direction <= bus_glue_pkg::RESET_HIGH_OFF;
        end
        else
        begin
            address_cs_n <= cpu_bus_release_ack_s;
            address_outbound <= 1'b1;
            ext_data_cs_n <= cpu_bus_release_ack_s | local_access;
            ext_data_inward <= any_read;
            local_mem_cs_n <= ~mem_select;
            transceiver_direction <= mem_read_s;
        end
    end

    // Ready stays low until a source answers, holding the processor in
    // wait states; the failsafe bounds the wait.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            local_io_ready_n <= bus_glue_pkg::RESET_LOW_OFF;
            cpu_ready_input <= bus_glue_pkg::RESET_HIGH_OFF;
        end
        else
        begin
            local_io_ready_n <= ~io_ready;
            cpu_ready_input <= ready_any;
        end
    end

    // Reset distribution. The bus line is open drain: drive low only.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_reset_n_o <= 1'b0;
            bus_reset_n_oe <= bus_glue_pkg::RESET_HIGH_OFF;
            cpu_reset <= bus_glue_pkg::RESET_CPU_HELD;
            board_reset <= bus_glue_pkg::RESET_CPU_HELD;
        end
        else
        begin
            bus_reset_n_o <= 1'b0;
            bus_reset_n_oe <= drive_reset_out;
            cpu_reset <= reset_seen;
            board_reset <= reset_seen;
        end
    end

    // divide by two
    // Each bus clock line gets its own toggling flop.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            common_clock_n <= bus_glue_pkg::RESET_HIGH_OFF;
            bus_clock_n <= bus_glue_pkg::RESET_HIGH_OFF;
        end
        else
        begin
            common_clock_n <= ~common_clock_n;
            bus_clock_n <= ~bus_clock_n;
        end
    end
endmodule

// ---- hw/failsafe_if.sv ----
// Signals shared between the bus glue and its failsafe timer.
interface failsafe_if;
    logic strobe;
    logic status_bit0;
    logic int_ack;
    logic timeout;
    modport timer
    (
        input  strobe,
        input  status_bit0,
        output int_ack,
        output timeout
    );
    modport glue
    (
        output strobe,
        output status_bit0,
        input  int_ack,
        input  timeout
    );
endinterface

// ---- hw/failsafe_timer.sv ----
// Failsafe one-shot: interrupt acknowledge ready and hung-cycle timeout.
module failsafe_timer
#(
    parameter int unsigned TIMEOUT_CYCLES = bus_glue_pkg::FAILSAFE_CYCLES
)
(
    input wire logic    core_clk,
    input wire logic    rst,
    failsafe_if.timer   fs
);
    localparam logic [19:0] LAST_COUNT = 20'(TIMEOUT_CYCLES - 1);

    bus_glue_pkg::failsafe_state_t state;
    bus_glue_pkg::failsafe_state_t next_state;
    logic [19:0]                   count;
    logic                          strobe_prev;
    wire                           strobe_start;
    wire                           count_done;

    // A machine cycle starts on the leading edge of the status strobe.
    assign strobe_start = fs.strobe & ~strobe_prev;
    assign count_done = (count == LAST_COUNT);
    assign fs.int_ack = (state == bus_glue_pkg::FS_INT_ACK);
    assign fs.timeout = (state == bus_glue_pkg::FS_TIMED_OUT);

    always_comb
    begin
        next_state = state;
        case (state)
            bus_glue_pkg::FS_COUNTING:
                if (strobe_start && fs.status_bit0)
                    next_state = bus_glue_pkg::FS_INT_ACK;
                else if (count_done)
                    next_state = bus_glue_pkg::FS_TIMED_OUT;
            bus_glue_pkg::FS_INT_ACK,
            bus_glue_pkg::FS_TIMED_OUT:
                if (strobe_start)
                    next_state = fs.status_bit0
                        ? bus_glue_pkg::FS_INT_ACK
                        : bus_glue_pkg::FS_COUNTING;
            default:
                next_state = bus_glue_pkg::FS_COUNTING;
        endcase
    end

    // counter cleared per strobe
    // Counting stops at terminal count, so a stall gives one timeout.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= bus_glue_pkg::FS_COUNTING;
            count <= bus_glue_pkg::FAILSAFE_COUNT_RESET;
            strobe_prev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            strobe_prev <= fs.strobe;
            if (strobe_start)
                count <= bus_glue_pkg::FAILSAFE_COUNT_RESET;
            else if (!count_done)
                count <= count + 20'h0_0001;
        end
    end
endmodule

// ---- verification/bus_far_side_model.sv ----
// Behavioural model of the other modules that share the system bus.
module bus_far_side_model
#(
    parameter int unsigned ACK_DELAY = 6
)
(
    input wire logic       core_clk,
    input wire logic       want_bus,
    input wire logic       force_reset,
    input wire logic [1:0] ack_style,
    input wire logic       io_read_command_n,
    input wire logic       mem_read_command_n,
    input wire logic       bus_reset_n_o,
    input wire logic       bus_reset_n_oe,
    output logic           bus_hold_request_n = 1'h1,
    output logic           transfer_ack_n = 1'h1,
    output logic           advanced_transfer_ack_n = 1'h1,
    output logic           bus_reset_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned waited = 0;
    wire         busy;
    assign busy = !io_read_command_n | !mem_read_command_n;
    // shared reset line
    // Pulled up: the line is low only while someone drives it.
    assign bus_reset_n_i = !(force_reset | (bus_reset_n_oe & !bus_reset_n_o));
    // hold and acknowledge
    // A slow slave: acknowledge ACK_DELAY cycles into a read command,
    // released to the pull-up level when it ends.
    always @(negedge core_clk)
    begin
        bus_hold_request_n <= !want_bus;
        waited <= busy ? waited + 1 : 0;
        transfer_ack_n <= !(busy && ack_style == 2'h1 && waited >= ACK_DELAY);
        advanced_transfer_ack_n <=
            !(busy && ack_style == 2'h2 && waited >= ACK_DELAY);
    end
endmodule

// ---- verification/cpu_bus_glue_asserts.sv ----
// Concurrent checks on the ports of the CPU to system bus glue.
module cpu_bus_glue_asserts
#(
    parameter int unsigned FAILSAFE_CYCLES = bus_glue_pkg::FAILSAFE_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic external_irq_one_n,
    input wire logic external_irq_two_n,
    input wire logic parallel_irq_n,
    input wire logic serial_irq_n,
    input wire logic bus_hold_request_n,
    input wire logic cpu_bus_release_ack,
    input wire logic power_up_reset,
    input wire logic reset_out_enable,
    input wire logic bus_reset_n_i,
    input wire logic bus_reset_n_oe,
    input wire logic serial_select_n,
    input wire logic parallel_a_select_n,
    input wire logic parallel_b_select_n,
    input wire logic io_read_level,
    input wire logic early_io_write_n,
    input wire logic cpu_write_strobe_n,
    input wire logic rom_ready_n,
    input wire logic rw_memory_ready_n,
    input wire logic advanced_transfer_ack_n,
    input wire logic transfer_ack_n,
    input wire logic status_strobe_n,
    input wire logic status_bit0,
    input wire logic cpu_irq,
    input wire logic cpu_hold,
    input wire logic latched_release_ack,
    input wire logic bus_in_use_n,
    input wire logic command_oe,
    input wire logic address_cs_n,
    input wire logic ext_data_cs_n,
    input wire logic local_io_ready_n,
    input wire logic io_write_command_n,
    input wire logic cpu_ready_input,
    input wire logic cpu_reset,
    input wire logic common_clock_n,
    input wire logic bus_clock_n,
    input wire logic local_mem_cs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0]  settle;
    logic        settled;
    int unsigned quiet;
    wire         irq_all_n;
    wire         io_hit;
    wire         io_wr_n;
    wire         mem_hit;
    wire         any_ready;
    // Pin causes, so each check can look three edges back at one signal.
    assign irq_all_n = external_irq_one_n & external_irq_two_n
        & parallel_irq_n & serial_irq_n;
    assign io_hit = !(serial_select_n & parallel_a_select_n
        & parallel_b_select_n) & (io_read_level | !early_io_write_n);
    assign io_wr_n = early_io_write_n | cpu_write_strobe_n;
    assign mem_hit = !rom_ready_n | !rw_memory_ready_n;
    assign any_ready = io_hit | mem_hit | !transfer_ack_n
        | !advanced_transfer_ack_n;
    assign settled = (settle == 3'h4);
    // Pin relations are trusted only once the synchronisers have filled.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            settle <= 3'h0;
            quiet <= 0;
        end
        else
        begin
            settle <= settled ? settle : settle + 3'h1;
            quiet <= $fell(status_strobe_n) ? 0 : quiet + 1;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_irq_merge: assert property (
        settled |-> cpu_irq == !$past(irq_all_n, 3))
        else $error("interrupt merge wrong");
    a_hold_invert: assert property (
        settled |-> cpu_hold == !$past(bus_hold_request_n, 3))
        else $error("hold request not inverted");
    a_hold_float: assert property (
        settled && $past(cpu_bus_release_ack, 3) |-> latched_release_ack
        && !command_oe && address_cs_n && ext_data_cs_n)
        else $error("drivers not floated in hold");
    a_busy_inverse: assert property (
        settled |-> bus_in_use_n == !$past(cpu_bus_release_ack, 3))
        else $error("bus in use wrong");
    a_io_ready: assert property (
        settled |-> local_io_ready_n == !$past(io_hit, 3))
        else $error("io ready wrong");
    a_write_qualify: assert property (
        settled |-> io_write_command_n == $past(io_wr_n, 3))
        else $error("io write command wrong");
    a_ready_merge: assert property (
        settled && $past(any_ready, 3) |-> cpu_ready_input)
        else $error("ready not merged");
    a_local_block: assert property (
        settled && $past(mem_hit, 3) |-> ext_data_cs_n && !local_mem_cs_n)
        else $error("local memory select wrong");
    a_clock_divide: assert property (
        settled |-> common_clock_n != $past(common_clock_n)
        && bus_clock_n == common_clock_n)
        else $error("bus clock not halved");
    a_reset_drive: assert property (
        settled && $past(power_up_reset, 3) && $past(reset_out_enable, 3)
        |-> ##[0:1] bus_reset_n_oe)
        else $error("reset not driven onto bus");
    a_reset_spread: assert property (
        settled && !$past(bus_reset_n_i, 3) |-> ##[0:1] cpu_reset)
        else $error("bus reset not applied");
    a_int_ack: assert property (
        $fell(status_strobe_n) && status_bit0 |-> ##[3:5] cpu_ready_input)
        else $error("interrupt acknowledge ready missing");
    a_timeout_fires: assert property (
        quiet == FAILSAFE_CYCLES + 6 |-> cpu_ready_input)
        else $error("failsafe timeout missing");
endmodule

bind cpu_bus_glue cpu_bus_glue_asserts
    #(.FAILSAFE_CYCLES(FAILSAFE_CYCLES)) cpu_bus_glue_asserts_inst (.*);

// ---- verification/cpu_system_bus_interface_tb.sv ----
// Self-checking testbench for the CPU to system bus glue.
module cpu_system_bus_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned FS = 50;
    logic core_clk = 1'h0, rst = 1'h1;
    logic external_irq_one_n = 1'h1, external_irq_two_n = 1'h1;
    logic parallel_irq_n = 1'h1, serial_irq_n = 1'h1;
    logic cpu_bus_release_ack = 1'h0, power_up_reset = 1'h0;
    logic reset_out_enable = 1'h1, early_mem_write_n = 1'h1;
    logic serial_select_n = 1'h1, parallel_a_select_n = 1'h1;
    logic parallel_b_select_n = 1'h1, io_read_level = 1'h0;
    logic early_io_write_n = 1'h1, cpu_write_strobe_n = 1'h1;
    logic memory_read_level = 1'h0, rom_ready_n = 1'h1;
    logic rw_memory_ready_n = 1'h1, status_strobe_n = 1'h1;
    logic status_bit0 = 1'h0, want_bus = 1'h0, force_reset = 1'h0;
    logic auto_strobe = 1'h1, man_strobe_n = 1'h1, man_bit0 = 1'h0, c;
    logic bus_hold_request_n, transfer_ack_n, advanced_transfer_ack_n;
    logic bus_reset_n_i, bus_reset_n_o, bus_reset_n_oe;
    logic cpu_irq, cpu_hold, latched_release_ack, bus_in_use_n;
    logic mem_read_command_n, mem_write_command_n, io_read_command_n;
    logic io_write_command_n, command_oe, address_cs_n, address_outbound;
    logic ext_data_cs_n, ext_data_inward, local_mem_cs_n;
    logic transceiver_direction, local_io_ready_n, cpu_ready_input;
    logic cpu_reset, board_reset, common_clock_n, bus_clock_n;
    logic [1:0] ack_style = 2'h0;
    int beat = 0, ticks = 0, num_errors = 0, compares = 0;

    cpu_bus_glue #(.FAILSAFE_CYCLES(FS)) cpu_bus_glue_inst (.*);
    bus_far_side_model bus_far_side_model_inst (.*);

    always #5 core_clk = ~core_clk;

    // A cycle starts every 20 clocks, keeping the failsafe quiet.
    always @(negedge core_clk)
    begin
        beat <= beat + 1;
        status_strobe_n <= auto_strobe ? (beat % 20 > 1) : man_strobe_n;
        status_bit0 <= auto_strobe ? 1'h0 : man_bit0;
    end

    // A hung run counts as a mismatch.
    always @(posedge core_clk)
    begin
        ticks++;
        if (ticks == 3000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t %s: got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wrap_up();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial
    begin
        cyc(16);
        rst = 1'h0;
        cyc(6);
        chk(address_outbound, 1'h1, "address direction");
        // Each request alone, then none.
        for (int i = 0; i < 5; i++)
        begin
            {external_irq_one_n, external_irq_two_n, parallel_irq_n,
                serial_irq_n} = ~(4'h1 << i);
            cyc(4);
            chk(cpu_irq, i < 4, "irq merge");
        end
        want_bus = 1'h1;
        cyc(4);
        chk(cpu_hold, 1'h1, "hold request");
        cpu_bus_release_ack = 1'h1;
        cyc(4);
        chk(command_oe, 1'h0, "commands float");
        chk(address_cs_n & ext_data_cs_n, 1'h1, "drivers float");
        chk(bus_in_use_n, 1'h0, "bus surrendered");
        want_bus = 1'h0;
        cpu_bus_release_ack = 1'h0;
        cyc(4);
        chk(command_oe & bus_in_use_n, 1'h1, "bus back");
        // Each select with read, then with early write, then none.
        for (int i = 0; i < 7; i++)
        begin
            {serial_select_n, parallel_a_select_n, parallel_b_select_n} =
                (i > 5) ? 3'h7 : ~(3'h1 << (i % 3));
            io_read_level = (i < 3);
            early_io_write_n = (i < 3);
            cyc(4);
            chk(local_io_ready_n, i > 5, "io ready");
            chk(cpu_ready_input, i < 6, "cpu ready");
            chk(ext_data_inward, i < 3, "data direction");
        end
        chk(io_write_command_n, 1'h1, "write before strobe");
        cpu_write_strobe_n = 1'h0;
        cyc(4);
        chk(io_write_command_n, 1'h0, "qualified write");
        {early_io_write_n, cpu_write_strobe_n} = 2'h3;
        {serial_select_n, parallel_a_select_n, parallel_b_select_n} = 3'h7;
        memory_read_level = 1'h1;
        rom_ready_n = 1'h0;
        cyc(4);
        chk(local_mem_cs_n | mem_read_command_n, 1'h0, "rom select");
        chk(transceiver_direction, 1'h1, "rom read direction");
        chk(ext_data_cs_n & cpu_ready_input, 1'h1, "local access");
        {memory_read_level, rom_ready_n, rw_memory_ready_n} = 3'h2;
        {early_mem_write_n, cpu_write_strobe_n} = 2'h0;
        cyc(4);
        chk(local_mem_cs_n | transceiver_direction, 1'h0, "ram write");
        chk(mem_write_command_n, 1'h0, "mem write");
        chk(ext_data_inward, 1'h0, "outward data");
        {rw_memory_ready_n, early_mem_write_n, cpu_write_strobe_n} = 3'h7;
        // A slow slave answers with each acknowledge in turn.
        for (int s = 1; s < 3; s++)
        begin
            ack_style = s;
            io_read_level = 1'h1;
            cyc(4);
            chk(cpu_ready_input | io_read_command_n, 1'h0, "waits");
            chk(ext_data_cs_n, 1'h0, "external data on");
            for (int k = 0; k < 20 && cpu_ready_input !== 1'h1; k++)
                cyc(1);
            chk(cpu_ready_input, 1'h1, "slave ready");
            io_read_level = 1'h0;
            cyc(6);
            chk(cpu_ready_input, 1'h0, "ready released");
        end
        force_reset = 1'h1;
        cyc(4);
        chk(cpu_reset & board_reset, 1'h1, "bus reset in");
        force_reset = 1'h0;
        power_up_reset = 1'h1;
        cyc(4);
        chk(bus_reset_n_oe, 1'h1, "reset out");
        reset_out_enable = 1'h0;
        cyc(4);
        chk(bus_reset_n_oe, 1'h0, "reset out off");
        power_up_reset = 1'h0;
        cyc(6);
        chk(cpu_reset | board_reset, 1'h0, "reset ends");
        c = common_clock_n;
        cyc(1);
        chk(common_clock_n, !c, "clock halved");
        chk(bus_clock_n, common_clock_n, "clock pair");
        // Interrupt acknowledge, its clearing, then a hung cycle.
        auto_strobe = 1'h0;
        for (int j = 0; j < 2; j++)
        begin
            man_bit0 = (j == 0);
            man_strobe_n = 1'h0;
            cyc(3);
            man_strobe_n = 1'h1;
            cyc(3);
            chk(cpu_ready_input, j == 0, "ack ready");
        end
        cyc(FS - 8);
        chk(cpu_ready_input, 1'h0, "no early timeout");
        cyc(12);
        chk(cpu_ready_input, 1'h1, "timeout ready");
        man_strobe_n = 1'h0;
        cyc(3);
        man_strobe_n = 1'h1;
        cyc(3);
        chk(cpu_ready_input, 1'h0, "retriggered");
        auto_strobe = 1'h1;
        wrap_up();
    end
endmodule
